// file: tcd_dispatcher.sv
// Functional notes
// - Keep 32-bit seconds count as time base
// - Update converts eight BCD digits, loads time
// - No answer or smaller value keeps time
// - Twenty-four timers, up to 32766 seconds
// - Timer reset stores negated refreshed time
// - Timer read adds negated start to time
// - Report minus one accepted, else plus one
// - Data-control word goes to flag location
// - Return timed pending command to its buffer
// - Manual command pends, flag set, time zero
// - Unrecognised inputs are power processor commands
// - Operational pseudocommand yields thruster status number
// - Throttle pseudocommand also yields throttle point
// - Two numbers form command plus unit address
// - Check reply; error handling or off-normal path
// - Insert parity before transmitting command word
// - No status location: abort, flag error
// - Retry to five attempts, then all errors
// - Save command; log setpoint commands, not telemetry
// - Echo and interpretation checks; drop enable on failure
// - Link bit rate 10 kHz from divider
// - Sustain at least 100 commands per second
`timescale 1ns/1ps
`default_nettype none
module tcd_dispatcher #(
	parameter int BIT_DIV = tcd_pkg::BIT_CYCLES,
	parameter int CMD_PERIOD = tcd_pkg::CMD_PERIOD_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic hwclk_req,
	input wire logic hwclk_ack,
	input wire logic [31:0] hwclk_bcd,
	input wire logic manual_valid,
	input wire logic [15:0] manual_word,
	input wire logic timed_valid,
	input wire logic [15:0] timed_cmd,
	input wire logic [31:0] timed_time,
	output logic timed_ready,
	output logic buf_ret_valid,
	output logic [15:0] buf_ret_cmd,
	output logic [31:0] buf_ret_time,
	output logic link_enable,
	output logic link_data,
	input wire logic link_echo,
	input wire logic link_resp,
	output logic err_req,
	output logic offn_req,
	output logic [15:0] offn_status,
	output logic log_valid,
	output logic [15:0] log_cmd
);
	localparam int FRAME = (tcd_pkg::CMD_BITS + 1 + tcd_pkg::RESP_BITS) * BIT_DIV;
	// One whole frame must fit the command period, or the command rate is lost
	initial begin
		if (BIT_DIV < 2 || FRAME > CMD_PERIOD) begin
			$error("tcd_dispatcher: link divider cannot sustain command rate");
		end
	end

	typedef enum {TK_IDLE, TK_ASK, TK_WAIT} tcd_tk_t;
	typedef enum {LK_IDLE, LK_LOCATE, LK_SEND, LK_RECV, LK_EVAL, LK_GAP} tcd_lk_t;

	// Decoded word: dc, pseudo, throttle, status[7:0], point[7:0]
	function automatic logic [18:0] tcd_decode(input logic [15:0] w);
		logic [7:0] st;
		logic ok;
		st = tcd_pkg::ST_PPU_CMD;
		ok = 1'b1;
		unique case (w[13:10])
			tcd_pkg::PC_START: st = tcd_pkg::ST_START;
			tcd_pkg::PC_THROTTLE: st = tcd_pkg::ST_THROTTLE;
			tcd_pkg::PC_SHUTDOWN: st = tcd_pkg::ST_SHUTDOWN;
			tcd_pkg::PC_PRECOND: st = tcd_pkg::ST_PRECOND;
			tcd_pkg::PC_NEUTRAL: st = tcd_pkg::ST_NEUTRAL;
			default: ok = 1'b0;
		endcase
		if (w[15:14] == tcd_pkg::CLASS_DATA_CTRL) begin
			tcd_decode = {3'b100, 8'h00, 8'h00};
		end else if (w[15:14] == tcd_pkg::CLASS_PSEUDO && ok) begin
			tcd_decode = {2'b01, w[13:10] == tcd_pkg::PC_THROTTLE, st, w[7:0]};
		end else begin
			tcd_decode = {3'b000, tcd_pkg::ST_PPU_CMD, 8'h00};
		end
	endfunction

	// Eight BCD digits to binary
	function automatic logic [31:0] tcd_bcd2bin(input logic [31:0] b);
		logic [31:0] acc;
		acc = 32'h0000_0000;
		for (int i = 7; i >= 0; i--) begin
			acc = 32'(acc * 32'd10) + {28'h000_0000, b[i*4 +: 4]};
		end
		tcd_bcd2bin = acc;
	endfunction

	// ---------------- Time base and interval timers ----------------
	tcd_tk_t tk_state;
	logic [31:0] cur_time;
	logic [31:0] start_neg [tcd_pkg::NUM_TIMERS];
	logic [31:0] elapsed;
	logic [1:0] tk_op;
	logic [4:0] tk_idx;
	logic [4:0] tk_wait;
	logic [31:0] hw_bin;
	logic [31:0] next_time;
	logic [31:0] sum;
	logic ctrl_wr;

	assign ctrl_wr = reg_wr && reg_addr == tcd_pkg::REG_CTRL && reg_wdata[1:0] != 2'h0
		&& reg_wdata[12:8] < 5'(tcd_pkg::NUM_TIMERS);
	assign hw_bin = tcd_bcd2bin(hwclk_bcd);
	// Refreshed time; a late or backward clock leaves it alone
	always_comb begin
		next_time = cur_time;
		if (tk_state == TK_WAIT && hwclk_ack && hw_bin >= cur_time) begin
			next_time = hw_bin;
		end
	end
	assign sum = next_time + start_neg[tk_idx];

	// Time keeper sequence: ask clock, wait bounded time, apply op
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			tk_state <= TK_IDLE;
			tk_op <= 2'h0;
			tk_idx <= 5'h00;
			tk_wait <= 5'h00;
		end else begin
			unique case (tk_state)
				TK_IDLE: if (ctrl_wr) begin
					tk_op <= reg_wdata[1:0];
					tk_idx <= reg_wdata[12:8];
					tk_state <= TK_ASK;
				end
				TK_ASK: begin
					tk_wait <= 5'h00;
					tk_state <= TK_WAIT;
				end
				TK_WAIT: begin
					tk_wait <= tk_wait + 5'h01;
					if (hwclk_ack || tk_wait == 5'(tcd_pkg::HWCLK_TIMEOUT - 1)) begin
						tk_state <= TK_IDLE;
					end
				end
			endcase
		end
	end
	assign hwclk_req = tk_state == TK_ASK;

	logic tk_done;
	assign tk_done = tk_state == TK_WAIT
		&& (hwclk_ack || tk_wait == 5'(tcd_pkg::HWCLK_TIMEOUT - 1));

	// Current time follows the refreshed value at completion
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cur_time <= 32'h0000_0000;
		end else if (tk_done) begin
			cur_time <= next_time;
		end
	end

	// Timer starts and elapsed result; elapsed saturates at the timer range
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			elapsed <= 32'h0000_0000;
			for (int i = 0; i < tcd_pkg::NUM_TIMERS; i++) begin
				start_neg[i] <= 32'h0000_0000;
			end
		end else if (tk_done && tk_op == tcd_pkg::OP_TRESET) begin
			start_neg[tk_idx] <= 32'(-next_time);
		end else if (tk_done && tk_op == tcd_pkg::OP_TREAD) begin
			elapsed <= (sum > tcd_pkg::TIMER_MAX) ? tcd_pkg::TIMER_MAX : sum;
		end
	end

	// ---------------- Manual input and pending slot ----------------
	logic [18:0] man_dec;
	logic [18:0] dec_reg;
	logic [31:0] man_result;
	logic [31:0] data_ctrl;
	logic [15:0] pend_cmd;
	logic [31:0] pend_time;
	logic pend_flag;
	logic man_cmd;
	logic pend_clr;
	logic result_rd;

	assign man_dec = tcd_decode(manual_word);
	assign man_cmd = manual_valid && !man_dec[18];
	assign pend_clr = reg_wr && reg_addr == tcd_pkg::REG_PENDING;
	assign result_rd = reg_rd && reg_addr == tcd_pkg::REG_MAN_RESULT;
	assign timed_ready = !pend_flag && !manual_valid;

	// Pending command slot; a new command wins over a software clear
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pend_flag <= 1'b0;
			pend_cmd <= 16'h0000;
			pend_time <= 32'h0000_0000;
		end else if (man_cmd) begin
			pend_flag <= 1'b1;
			pend_cmd <= manual_word;
			pend_time <= 32'h0000_0000;
		end else if (timed_valid && timed_ready) begin
			pend_flag <= 1'b1;
			pend_cmd <= timed_cmd;
			pend_time <= timed_time;
		end else if (pend_clr) begin
			pend_flag <= 1'b0;
		end
	end

	// Displaced timed command goes back to its buffer with its time
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			buf_ret_valid <= 1'b0;
			buf_ret_cmd <= 16'h0000;
			buf_ret_time <= 32'h0000_0000;
		end else begin
			buf_ret_valid <= man_cmd && pend_flag && pend_time != 32'h0000_0000;
			if (man_cmd && pend_flag) begin
				buf_ret_cmd <= pend_cmd;
				buf_ret_time <= pend_time;
			end
		end
	end

	// Result code; an acceptance in the read cycle is kept for next read
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			man_result <= tcd_pkg::RES_NONE;
			data_ctrl <= 32'h0000_0000;
			dec_reg <= 19'h0_0000;
		end else begin
			if (man_cmd) begin
				man_result <= tcd_pkg::RES_ACCEPTED;
			end else if (result_rd) begin
				man_result <= tcd_pkg::RES_NONE;
			end
			if (manual_valid) begin
				dec_reg <= man_dec;
			end
			if (manual_valid && man_dec[18]) begin
				data_ctrl <= {16'h0000, manual_word};
			end
		end
	end

	// ---------------- Command generator and link driver ----------------
	tcd_lk_t lk_state;
	logic [3:0] unit_addr;
	logic [15:0] cmd_word;
	logic [16:0] tx_shift;
	logic [15:0] rx_shift;
	logic [5:0] bit_cnt;
	logic [2:0] attempts;
	logic echo_bad;
	logic intstat_phase;
	logic link_ok;
	logic link_fail;
	logic [15:0] status_blk [tcd_pkg::NUM_UNITS];
	logic [$clog2(BIT_DIV)-1:0] div_cnt;
	logic bit_tick;
	logic gen_wr;
	logic xfer_err;
	logic offn_seen;

	assign gen_wr = reg_wr && reg_addr == tcd_pkg::REG_GEN && lk_state == LK_IDLE;
	assign xfer_err = echo_bad || rx_shift[tcd_pkg::RESP_INTERP_ERR];
	assign offn_seen = rx_shift[tcd_pkg::RESP_OFFNORMAL];

	// Bit rate divider, restarted for every frame so a retry's first bit is not cut short
	always_ff @(posedge clk) begin
		if (!rst_b || !(lk_state == LK_SEND || lk_state == LK_RECV)) begin
			div_cnt <= '0;
		end else if (div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1)) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + 1'b1;
		end
	end
	assign bit_tick = div_cnt == ($clog2(BIT_DIV))'(BIT_DIV - 1);

	// Unit being served
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			unit_addr <= 4'h0;
		end else if (reg_wr && reg_addr == tcd_pkg::REG_UNIT) begin
			unit_addr <= reg_wdata[3:0];
		end
	end

	// Link sequencer: locate, send with echo, receive reply, judge
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lk_state <= LK_IDLE;
			cmd_word <= 16'h0000;
			tx_shift <= 17'h0_0000;
			rx_shift <= 16'h0000;
			bit_cnt <= 6'h00;
			attempts <= 3'h0;
			echo_bad <= 1'b0;
			intstat_phase <= 1'b0;
		end else begin
			unique case (lk_state)
				LK_IDLE: if (gen_wr) begin
					cmd_word <= {unit_addr, reg_wdata[13:8], reg_wdata[5:0]};
					intstat_phase <= 1'b0;
					attempts <= 3'h0;
					lk_state <= LK_LOCATE;
				end
				LK_LOCATE: begin
					if (cmd_word[15:12] >= 4'(tcd_pkg::NUM_UNITS)) begin
						lk_state <= LK_IDLE;
					end else begin
						tx_shift <= {~^cmd_word, cmd_word};
						bit_cnt <= 6'h00;
						echo_bad <= 1'b0;
						attempts <= attempts + 3'h1;
						lk_state <= LK_SEND;
					end
				end
				LK_SEND: if (bit_tick) begin
					if (link_echo != tx_shift[16]) begin
						echo_bad <= 1'b1;
					end
					tx_shift <= {tx_shift[15:0], 1'b0};
					bit_cnt <= bit_cnt + 6'h01;
					if (bit_cnt == 6'(tcd_pkg::CMD_BITS)) begin
						bit_cnt <= 6'h00;
						lk_state <= LK_RECV;
					end
				end
				LK_RECV: if (bit_tick) begin
					rx_shift <= {rx_shift[14:0], link_resp};
					bit_cnt <= bit_cnt + 6'h01;
					if (bit_cnt == 6'(tcd_pkg::RESP_BITS - 1)) begin
						lk_state <= LK_EVAL;
					end
				end
				LK_EVAL: begin
					if (xfer_err && attempts < 3'(tcd_pkg::MAX_ATTEMPTS)) begin
						lk_state <= LK_GAP;
					end else if (!xfer_err && offn_seen && !intstat_phase) begin
						cmd_word <= {cmd_word[15:12], tcd_pkg::FUNC_INTSTAT, 6'h00};
						intstat_phase <= 1'b1;
						attempts <= 3'h0;
						lk_state <= LK_GAP;
					end else begin
						lk_state <= LK_IDLE;
					end
				end
				LK_GAP: lk_state <= LK_LOCATE;
			endcase
		end
	end

	// Enable drops after a failed frame and stays low between attempts
	assign link_enable = lk_state == LK_SEND || lk_state == LK_RECV;
	assign link_data = lk_state == LK_SEND && tx_shift[16];
	assign link_ok = lk_state == LK_EVAL && !xfer_err;
	assign link_fail = lk_state == LK_EVAL && xfer_err
		&& attempts >= 3'(tcd_pkg::MAX_ATTEMPTS);

	// Outcome flags, status blocks, logging and handler requests
	logic [3:0] link_flags;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			err_req <= 1'b0;
			offn_req <= 1'b0;
			offn_status <= 16'h0000;
			log_valid <= 1'b0;
			log_cmd <= 16'h0000;
			link_flags <= 4'h0;
			for (int i = 0; i < tcd_pkg::NUM_UNITS; i++) begin
				status_blk[i] <= 16'h0000;
			end
		end else begin
			err_req <= link_fail
				|| (lk_state == LK_LOCATE && cmd_word[15:12] >= 4'(tcd_pkg::NUM_UNITS));
			offn_req <= link_ok && intstat_phase;
			log_valid <= link_ok && cmd_word[11:6] >= tcd_pkg::FUNC_TLM_LIMIT;
			if (link_ok) begin
				status_blk[cmd_word[14:12]] <= cmd_word;
				log_cmd <= cmd_word;
				link_flags <= 4'h1;
				if (intstat_phase) begin
					offn_status <= rx_shift;
				end
			end
			if (link_fail) begin
				link_flags <= 4'hE;
			end
			if (lk_state == LK_LOCATE && cmd_word[15:12] >= 4'(tcd_pkg::NUM_UNITS)) begin
				link_flags <= 4'h2;
			end
		end
	end

	// Register read port, data valid the cycle after the strobe
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				tcd_pkg::REG_CTRL: reg_rdata <= {30'h0, lk_state != LK_IDLE, tk_state != TK_IDLE};
				tcd_pkg::REG_TIME: reg_rdata <= cur_time;
				tcd_pkg::REG_ELAPSED: reg_rdata <= elapsed;
				tcd_pkg::REG_MAN_RESULT: reg_rdata <= man_result;
				tcd_pkg::REG_PENDING: reg_rdata <= {15'h0, pend_flag, pend_cmd};
				tcd_pkg::REG_DECODE: reg_rdata <= {13'h0, dec_reg};
				tcd_pkg::REG_UNIT: reg_rdata <= {28'h0, unit_addr};
				tcd_pkg::REG_LINK: reg_rdata <= {9'h0, attempts, link_flags, rx_shift};
				tcd_pkg::REG_DATA_CTRL: reg_rdata <= data_ctrl;
				tcd_pkg::REG_STATUS_BLK: reg_rdata <= {16'h0, status_blk[unit_addr[2:0]]};
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ---------------- Checks ----------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_time_monotonic: assert property (cur_time >= $past(cur_time)) else $error("time went back");
	a_time_load: assert property (tk_state == TK_WAIT && hwclk_ack && hw_bin >= cur_time
		|=> cur_time == $past(hw_bin)) else $error("clock update lost");
	a_man_accept: assert property (man_cmd |=> pend_flag && pend_time == 32'h0 && man_result == 32'hFFFF_FFFF)
		else $error("manual accept wrong");
	a_dc_no_pend: assert property (manual_valid && man_dec[18] && !pend_flag && !timed_valid
		|=> !pend_flag ##0 data_ctrl[15:0] == $past(manual_word)) else $error("data word pended");
	a_buf_return: assert property (man_cmd && pend_flag && pend_time != 32'h0
		|=> buf_ret_valid && buf_ret_time == $past(pend_time)) else $error("timed command lost");
	a_parity_odd: assert property (lk_state == LK_SEND && bit_cnt == 6'h00 |-> ^tx_shift == 1'b1)
		else $error("bad parity");
	a_attempt_cap: assert property (attempts <= 3'd5) else $error("too many attempts");
	a_fail_err: assert property (link_fail |=> err_req && link_flags == 4'hE) else $error("no error");
	a_bad_unit: assert property (lk_state == LK_LOCATE && cmd_word[15:12] >= 4'd8
		|=> lk_state == LK_IDLE && !link_enable) else $error("sent to bad unit");
	a_enable_drop: assert property (lk_state == LK_EVAL |-> !link_enable) else $error("enable held");

	c_manual_cmd: cover property (man_cmd ##1 buf_ret_valid);
	c_retry: cover property (lk_state == LK_EVAL && xfer_err ##1 lk_state == LK_GAP);
	c_offnormal: cover property (offn_req);
	c_timer_read: cover property (tk_done && tk_op == tcd_pkg::OP_TREAD);
endmodule
`default_nettype wire

// file: tcd_pkg.sv
`default_nettype none
package tcd_pkg;
	// Clock and link timing
	localparam int CLK_HZ = 10_000_000;
	localparam int LINK_BIT_HZ = 10_000;
	localparam int BIT_CYCLES = CLK_HZ / LINK_BIT_HZ;
	localparam int CMD_PER_SEC = 100;
	localparam int CMD_PERIOD_CYCLES = CLK_HZ / CMD_PER_SEC;
	localparam int HWCLK_TIMEOUT = 16;
	// Timers and retries
	localparam int NUM_TIMERS = 24;
	localparam logic [31:0] TIMER_MAX = 32'h0000_7FFE;
	localparam int MAX_ATTEMPTS = 5;
	localparam int NUM_UNITS = 8;
	// Link frame layout
	localparam int CMD_BITS = 16;
	localparam int RESP_BITS = 16;
	localparam int RESP_INTERP_ERR = 15;
	localparam int RESP_OFFNORMAL = 14;
	localparam logic [5:0] FUNC_TLM_LIMIT = 6'h10;
	localparam logic [5:0] FUNC_INTSTAT = 6'h0F;
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_TIME = 8'h04;
	localparam logic [7:0] REG_ELAPSED = 8'h08;
	localparam logic [7:0] REG_MAN_RESULT = 8'h0C;
	localparam logic [7:0] REG_PENDING = 8'h10;
	localparam logic [7:0] REG_DECODE = 8'h14;
	localparam logic [7:0] REG_GEN = 8'h18;
	localparam logic [7:0] REG_UNIT = 8'h1C;
	localparam logic [7:0] REG_LINK = 8'h20;
	localparam logic [7:0] REG_DATA_CTRL = 8'h24;
	localparam logic [7:0] REG_STATUS_BLK = 8'h28;
	// Time operations in CTRL[1:0], timer index in CTRL[12:8]
	localparam logic [1:0] OP_UPDATE = 2'h1;
	localparam logic [1:0] OP_TRESET = 2'h2;
	localparam logic [1:0] OP_TREAD = 2'h3;
	// Manual word classes and pseudocommand codes
	localparam logic [1:0] CLASS_DATA_CTRL = 2'h3;
	localparam logic [1:0] CLASS_PSEUDO = 2'h2;
	localparam logic [3:0] PC_START = 4'h1;
	localparam logic [3:0] PC_THROTTLE = 4'h2;
	localparam logic [3:0] PC_SHUTDOWN = 4'h3;
	localparam logic [3:0] PC_PRECOND = 4'h4;
	localparam logic [3:0] PC_NEUTRAL = 4'h5;
	localparam logic [7:0] ST_START = 8'h02;
	localparam logic [7:0] ST_THROTTLE = 8'h0A;
	localparam logic [7:0] ST_SHUTDOWN = 8'h00;
	localparam logic [7:0] ST_PRECOND = 8'h01;
	localparam logic [7:0] ST_NEUTRAL = 8'h37;
	localparam logic [7:0] ST_PPU_CMD = 8'hFF;
	// Manual result codes
	localparam logic [31:0] RES_ACCEPTED = 32'hFFFF_FFFF;
	localparam logic [31:0] RES_NONE = 32'h0000_0001;
endpackage
`default_nettype wire

// file: tcd_ppu_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-side power processor: echoes each bit and answers with a reply word
module tcd_ppu_model #(
	parameter int BIT_DIV = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_enable,
	input wire logic link_data,
	output logic link_echo,
	output logic link_resp,
	input wire logic [31:0] bad_upto,
	input wire logic [31:0] ierr_upto,
	input wire logic [15:0] reply,
	input wire logic [15:0] stat_reply,
	output logic [31:0] frames,
	output logic [16:0] last_cmd
);
	int cyc;
	int j;
	logic en_q;
	logic tog;
	logic [16:0] sh;
	logic [15:0] word;
	// Bits are taken one bit period apart from the enable edge, away from any tick
	always_ff @(posedge clk) begin
		tog <= rst_b ? ~tog : 1'b0;
		en_q <= link_enable;
		if (!rst_b) begin
			cyc <= 0;
			frames <= 32'h0;
		end else begin
			cyc <= link_enable ? cyc + 1 : 0;
			if (link_enable && cyc % BIT_DIV == 0 && cyc / BIT_DIV < 17)
				sh <= {sh[15:0], link_data};
			if (en_q && !link_enable) begin
				frames <= frames + 32'h1;
				last_cmd <= sh;
			end
		end
	end
	// Chosen frames report an interpretation error; status reads get their own word
	assign word = (frames < ierr_upto) ? 16'h8000 :
		(sh[11:6] == tcd_pkg::FUNC_INTSTAT) ? stat_reply : reply;
	assign j = (cyc - 1) / BIT_DIV - 17;
	// Lines toggle outside their window so a stale level can never pass
	assign link_resp = (link_enable && j >= 0 && j < 16) ? word[15 - j] : tog;
	assign link_echo = link_enable ? link_data ^ (frames < bad_upto) : tog;
endmodule
`default_nettype wire

// file: thruster_command_dispatcher_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module thruster_command_dispatcher_tb_top;
	logic clk, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, manual_valid = 1'b0;
	logic timed_valid = 1'b0, clk_ans = 1'b1, ack_d = 1'b0, hwclk_ack = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0, hwclk_bcd = 32'h0, timed_time = 32'h0, clk_bcd = 32'h0;
	logic [31:0] bad_upto = 32'h0, ierr_upto = 32'h0, seed = 32'h9B683986;
	logic [15:0] manual_word = 16'h0, timed_cmd = 16'h0, reply = 16'h0, stat_reply = 16'h0;
	logic [31:0] reg_rdata, buf_ret_time, ret_time, frames, r, r2, t, d;
	logic [15:0] buf_ret_cmd, log_cmd, offn_status, ret_cmd, last_log, last_offn, w;
	logic hwclk_req, timed_ready, buf_ret_valid, link_enable, link_data, link_echo, link_resp;
	logic err_req, offn_req, log_valid;
	logic [16:0] last_cmd;
	int errors = 0, num_checks = 0, n_err = 0, n_offn = 0, n_log = 0, n_ret = 0, i, o0;

	tcd_dispatcher #(.BIT_DIV(4), .CMD_PERIOD(200)) u_tcd_dispatcher (.clk(clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .hwclk_req(hwclk_req), .hwclk_ack(hwclk_ack),
		.hwclk_bcd(hwclk_bcd), .manual_valid(manual_valid), .manual_word(manual_word),
		.timed_valid(timed_valid), .timed_cmd(timed_cmd), .timed_time(timed_time),
		.timed_ready(timed_ready), .buf_ret_valid(buf_ret_valid), .buf_ret_cmd(buf_ret_cmd),
		.buf_ret_time(buf_ret_time), .link_enable(link_enable), .link_data(link_data),
		.link_echo(link_echo), .link_resp(link_resp), .err_req(err_req), .offn_req(offn_req),
		.offn_status(offn_status), .log_valid(log_valid), .log_cmd(log_cmd));
	tcd_ppu_model #(.BIT_DIV(4)) u_tcd_ppu_model (.clk(clk), .rst_b(rst_b),
		.link_enable(link_enable), .link_data(link_data), .link_echo(link_echo),
		.link_resp(link_resp), .bad_upto(bad_upto), .ierr_upto(ierr_upto), .reply(reply),
		.stat_reply(stat_reply), .frames(frames), .last_cmd(last_cmd));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Pulses are counted as they pass so later checks need no exact timing
	always @(posedge clk) begin
		if (err_req === 1'b1)
			n_err++;
		if (log_valid === 1'b1) begin
			n_log++;
			last_log = log_cmd;
		end
		if (offn_req === 1'b1) begin
			n_offn++;
			last_offn = offn_status;
		end
		if (buf_ret_valid === 1'b1) begin
			n_ret++;
			ret_cmd = buf_ret_cmd;
			ret_time = buf_ret_time;
		end
	end
	// Hardware clock answers two cycles after a request, only while allowed
	always @(posedge clk) begin
		ack_d <= hwclk_req & clk_ans;
		hwclk_ack <= ack_d;
		hwclk_bcd <= ack_d ? clk_bcd : ~clk_bcd;
	end

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
		return seed;
	endfunction
	function automatic logic [31:0] to_bcd(input logic [31:0] v);
		logic [31:0] b;
		for (int k = 0; k < 8; k++) begin
			b[4*k +: 4] = 4'(v % 10);
			v = v / 10;
		end
		return b;
	endfunction
	function automatic logic [31:0] exp_dec(input int k, input logic [7:0] pt);
		logic [7:0] st;
		case (k)
			1: st = tcd_pkg::ST_START;
			2: st = tcd_pkg::ST_THROTTLE;
			3: st = tcd_pkg::ST_SHUTDOWN;
			4: st = tcd_pkg::ST_PRECOND;
			default: st = tcd_pkg::ST_NEUTRAL;
		endcase
		return {13'h0, 2'b01, k == 2, st, (k == 2) ? pt : 8'h0};
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rdck(input logic [7:0] a, input logic [31:0] m, e, input string n);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(n, e, reg_rdata & m);
	endtask
	// Polls a busy bit; a hang here counts as a mismatch
	task automatic wait_idle(input int b);
		repeat (2) @(posedge clk);
		for (int k = 0; k < 3000; k++) begin
			@(posedge clk);
			reg_addr <= tcd_pkg::REG_CTRL;
			reg_rd <= 1'b1;
			@(posedge clk);
			reg_rd <= 1'b0;
			#1 if (reg_rdata[b] === 1'b0) break;
		end
		chk("busy bit", 32'h0, {31'h0, reg_rdata[b]});
	endtask
	task automatic tk(input logic [1:0] op, input logic [4:0] idx, input logic [31:0] tv);
		clk_bcd = to_bcd(tv);
		wr(tcd_pkg::REG_CTRL, {19'h0, idx, 6'h0, op});
		wait_idle(0);
	endtask
	task automatic man(input logic [15:0] v);
		@(posedge clk);
		manual_valid <= 1'b1;
		manual_word <= v;
		@(posedge clk);
		manual_valid <= 1'b0;
		manual_word <= ~v;
	endtask
	task automatic link(input logic [3:0] u, input logic [5:0] f, v, input int bad, ie,
			input logic [3:0] ef, input logic [2:0] ea);
		logic [15:0] c;
		logic [31:0] f0;
		int l0, e0;
		c = {u, f, v};
		f0 = frames;
		l0 = n_log;
		e0 = n_err;
		bad_upto = frames + bad;
		ierr_upto = frames + ie;
		wr(tcd_pkg::REG_UNIT, {28'h0, u});
		wr(tcd_pkg::REG_GEN, {18'h0, f, 2'h0, v});
		wait_idle(1);
		rdck(tcd_pkg::REG_LINK, (ef == 4'h2) ? 32'h000F_0000 : 32'h007F_0000,
			{9'h0, ea, ef, 16'h0}, "link status");
		chk("error request", 32'(e0 + (ef != 4'h1)), 32'(n_err));
		if (!reply[14])
			chk("frames", (ef == 4'h2) ? 32'h0 : {29'h0, ea}, frames - f0);
		if (ef == 4'h1 && !reply[14]) begin
			chk("wire command", {15'h0, ~^c, c}, {15'h0, last_cmd});
			rdck(tcd_pkg::REG_STATUS_BLK, 32'hFFFF, {16'h0, c}, "status block");
			chk("log count", 32'(l0 + (f >= 6'h10)), 32'(n_log));
			if (f >= 6'h10)
				chk("logged", {16'h0, c}, {16'h0, last_log});
		end
	endtask

	initial begin
		#(30000 * 100);
		errors++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		rdck(tcd_pkg::REG_MAN_RESULT, '1, tcd_pkg::RES_NONE, "result at reset");
		rdck(8'hFC, '1, 32'h0, "unmapped");
		// Time base: refresh, plain read, older and silent clock
		t = 32'd1000000 + rnd() % 32'd50000000;
		tk(tcd_pkg::OP_UPDATE, 5'h0, t);
		rdck(tcd_pkg::REG_TIME, '1, t, "time update");
		clk_bcd = to_bcd(t + 9);
		rdck(tcd_pkg::REG_TIME, '1, t, "plain read");
		tk(tcd_pkg::OP_UPDATE, 5'h0, t - 5);
		rdck(tcd_pkg::REG_TIME, '1, t, "older clock");
		clk_ans = 1'b0;
		tk(tcd_pkg::OP_UPDATE, 5'h0, t + 7);
		rdck(tcd_pkg::REG_TIME, '1, t, "silent clock");
		clk_ans = 1'b1;
		$display("test time base done");
		// Interval timers at both ends of the bank, and saturation
		d = rnd() % 32'd30000;
		tk(tcd_pkg::OP_TRESET, 5'd23, t + 10);
		tk(tcd_pkg::OP_TRESET, 5'd0, t + 10);
		tk(tcd_pkg::OP_TREAD, 5'd23, t + 10 + d);
		rdck(tcd_pkg::REG_ELAPSED, '1, d, "elapsed");
		rdck(tcd_pkg::REG_TIME, '1, t + 10 + d, "refreshed");
		tk(tcd_pkg::OP_TREAD, 5'd0, t + 40010);
		rdck(tcd_pkg::REG_ELAPSED, '1, tcd_pkg::TIMER_MAX, "saturated");
		$display("test timers done");
		// Manual inputs: data-control word, every pseudocommand
		r = rnd();
		w = {2'b11, r[13:0]};
		man(w);
		rdck(tcd_pkg::REG_DATA_CTRL, 32'hFFFF, {16'h0, w}, "data control");
		rdck(tcd_pkg::REG_MAN_RESULT, '1, tcd_pkg::RES_NONE, "dc result");
		rdck(tcd_pkg::REG_DECODE, 32'h40000, 32'h40000, "dc class");
		for (int k = 1; k <= 5; k++) begin
			r = rnd();
			man({2'b10, 4'(k), 2'b00, r[7:0]});
			rdck(tcd_pkg::REG_MAN_RESULT, '1, tcd_pkg::RES_ACCEPTED, "accepted");
			rdck(tcd_pkg::REG_DECODE, (k == 2) ? 32'h7FFFF : 32'h7FF00,
				exp_dec(k, r[7:0]), "pseudo decode");
		end
		rdck(tcd_pkg::REG_MAN_RESULT, '1, tcd_pkg::RES_NONE, "result cleared");
		wr(tcd_pkg::REG_PENDING, 32'h0);
		w = {2'b01, r[13:0]};
		man(w);
		rdck(tcd_pkg::REG_PENDING, 32'h1FFFF, {15'h0, 1'b1, w}, "pending");
		rdck(tcd_pkg::REG_DECODE, 32'hFF00, {16'h0, tcd_pkg::ST_PPU_CMD, 8'h0}, "ppu");
		chk("no return", 32'h0, 32'(n_ret));
		// A timed command waiting is pushed back by a manual one
		wr(tcd_pkg::REG_PENDING, 32'h0);
		r2 = rnd() | 32'h1;
		@(posedge clk);
		timed_valid <= 1'b1;
		timed_cmd <= r[31:16];
		timed_time <= r2;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (timed_ready !== 1'b1 && i < 20);
		timed_valid <= 1'b0;
		w = {2'b00, r[13:0]};
		man(w);
		repeat (3) @(posedge clk);
		chk("returned", 32'h1, 32'(n_ret));
		chk("returned cmd", {16'h0, r[31:16]}, {16'h0, ret_cmd});
		chk("returned time", r2, ret_time);
		rdck(tcd_pkg::REG_PENDING, 32'h1FFFF, {15'h0, 1'b1, w}, "manual pends");
		$display("test manual input done");
		// Link transfers: clean, telemetry, retries, exhausted, no location
		for (int k = 0; k < 3; k++) begin
			r = rnd();
			link({1'b0, r[18:16]}, r[13:8] | 6'h10, r[5:0], 0, 0, 4'h1, 3'd1);
		end
		link(4'h3, 6'h05, 6'h2A, 0, 0, 4'h1, 3'd1);
		link(4'h5, 6'h20, 6'h11, 2, 0, 4'h1, 3'd3);
		link(4'h1, 6'h21, 6'h01, 0, 1, 4'h1, 3'd2);
		link(4'h7, 6'h22, 6'h3F, 5, 0, 4'hE, 3'd5);
		link(4'h8, 6'h23, 6'h00, 0, 0, 4'h2, 3'd0);
		// Off-normal reply leads to a status read and a correction request
		r = rnd();
		reply = {2'b01, r[13:0]};
		stat_reply = {1'b0, r[30:16]};
		o0 = n_offn;
		link(4'h2, 6'h12, 6'h05, 0, 0, 4'h1, 3'd1);
		chk("offnormal", 32'(o0 + 1), 32'(n_offn));
		chk("int status", {16'h0, stat_reply}, {16'h0, last_offn});
		chk("status read", {26'h0, tcd_pkg::FUNC_INTSTAT}, {26'h0, last_cmd[11:6]});
		$display("test link done");
		close_out();
	end
endmodule
`default_nettype wire
